// file: verilog/srw_top.sv
// SYSREF windowing unit with aperture-delay ramp and register port
`timescale 1ns/1ps
`default_nettype none
`include "srw_defs.svh"
module srw_top #(
   parameter int RAMP_PERIOD = `SRW_RAMP_PERIOD
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire srw_pkg::srw_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // SYSREF samples at each delayed clock tap
   input wire logic [`SRW_TAPS-1:0] sysref_rise_taps_i,
   input wire logic [`SRW_TAPS-1:0] sysref_fall_taps_i,
   // Clocking controls
   output logic [`SRW_CODE_W-1:0] coarse_delay_o,
   output logic window_step_fine_o,
   output logic dual_edge_sample_o,
   // Captured SYSREF
   output logic sysref_captured_o,
   output logic sysref_event_o
);
   srw_pkg::srw_state_t st;
   srw_pkg::srw_state_t next_st;
   logic wr_clk;
   logic wr_coarse;
   logic wr_ramp;
   logic [`SRW_CODE_W-1:0] ramp_target;
   logic [`SRW_CODE_W-1:0] ramp_applied;
   logic ramp_busy;
   logic [`SRW_TAPS-1:0] diff;
   logic [`SRW_TAPS-1:0] risky;
   logic [`SRW_TAPS-1:0] status;
   logic rise_seen;
   logic pos_valid;
   logic tap_rise;
   logic tap_fall;
   logic capture_now;

   // Write decode
   assign wr_clk = reg_req_i.wr && (reg_req_i.addr == `SRW_REG_CLK_CTRL);
   assign wr_coarse = reg_req_i.wr && (reg_req_i.addr == `SRW_REG_COARSE);
   assign wr_ramp = reg_req_i.wr && (reg_req_i.addr == `SRW_REG_RAMP_CTRL);

   // Coarse delay ramp
   srw_delay_ramp #(
      .PERIOD(RAMP_PERIOD)
   ) u_ramp (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .code_wr_i(wr_coarse),
      .code_i(reg_req_i.wdata),
      .ramp_en_i(st.ramp_en),
      .ramp_fast_i(st.ramp_fast),
      .target_o(ramp_target),
      .applied_o(ramp_applied),
      .busy_o(ramp_busy)
   );

   // Neighbour transitions across the tap vector
   always_comb
   begin
      diff = '0;
      risky = '0;
      for (int i = 0; i < `SRW_TAPS - 1; i++)
      begin
         diff[i] = sysref_rise_taps_i[i] ^ sysref_rise_taps_i[i+1];
      end
      for (int i = 0; i < `SRW_TAPS; i++)
      begin
         if (i == 0)
         begin
            risky[i] = diff[i];
         end
         else
         begin
            risky[i] = diff[i] | diff[i-1];
         end
      end
   end

   // First cycle in which any tap rises out of an all-low vector
   assign rise_seen = (|(sysref_rise_taps_i & ~st.prev_taps)) && (st.prev_taps == '0);

   // Status: union of the last two edges, end taps forced high
   assign status = st.flags | st.flags_prev | `SRW_EDGE_UNKNOWN;
   assign pos_valid = (st.edge_cnt >= 2'(`SRW_EDGES_VALID));

   // Tap selection; select field reaches taps 0 to 15 only
   assign tap_rise = sysref_rise_taps_i[st.sel];
   assign tap_fall = sysref_fall_taps_i[st.sel];
   assign capture_now = st.single ? (tap_rise | tap_fall) : tap_rise;

   always_comb
   begin
      next_st = st;
      next_st.prev_taps = sysref_rise_taps_i;
      next_st.capture = capture_now;
      next_st.event_pulse = capture_now & ~st.capture;

      // Clock control fields
      if (wr_clk)
      begin
         next_st.sel = reg_req_i.wdata[`SRW_SEL_LSB +: `SRW_SEL_W];
         next_st.fine = reg_req_i.wdata[`SRW_FINE_BIT];
         next_st.single = reg_req_i.wdata[`SRW_SINGLE_BIT];
      end

      // Ramp control fields
      if (wr_ramp)
      begin
         next_st.ramp_en = reg_req_i.wdata[`SRW_RAMP_EN_BIT];
         next_st.ramp_fast = reg_req_i.wdata[`SRW_RAMP_FAST_BIT];
      end

      // Tap spacing change invalidates the history
      if (wr_clk && (reg_req_i.wdata[`SRW_FINE_BIT] != st.fine))
      begin
         next_st.flags = '0;
         next_st.flags_prev = '0;
         next_st.edge_cnt = 2'h0;
      end

      // Position tracking on every SYSREF rising edge; an edge wins over a clear
      if (rise_seen)
      begin
         next_st.flags_prev = next_st.flags;
         next_st.flags = risky;
         if (next_st.edge_cnt < 2'(`SRW_EDGES_VALID))
         begin
            next_st.edge_cnt = next_st.edge_cnt + 2'h1;
         end
      end

      // Read data, one cycle after the strobe
      next_st.rdata = 8'h00;
      if (reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            `SRW_REG_CLK_CTRL:
            begin
               next_st.rdata[`SRW_SEL_LSB +: `SRW_SEL_W] = st.sel;
               next_st.rdata[`SRW_FINE_BIT] = st.fine;
               next_st.rdata[`SRW_SINGLE_BIT] = st.single;
            end
            `SRW_REG_POS_LOW:
            begin
               next_st.rdata = status[7:0];
            end
            `SRW_REG_POS_MID:
            begin
               next_st.rdata = status[15:8];
            end
            `SRW_REG_POS_HIGH:
            begin
               next_st.rdata = status[23:16];
            end
            `SRW_REG_POS_VALID:
            begin
               next_st.rdata[`SRW_VALID_BIT] = pos_valid;
            end
            `SRW_REG_COARSE:
            begin
               next_st.rdata = ramp_applied;
            end
            `SRW_REG_RAMP_CTRL:
            begin
               next_st.rdata[`SRW_RAMP_EN_BIT] = st.ramp_en;
               next_st.rdata[`SRW_RAMP_FAST_BIT] = st.ramp_fast;
            end
            `SRW_REG_RAMP_STAT:
            begin
               next_st.rdata[`SRW_RAMP_BUSY_BIT] = ramp_busy;
               next_st.rdata[7:1] = 7'(ramp_target >> 1) & 7'h00;
            end
            default:
            begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs
   assign reg_rdata_o = st.rdata;
   assign coarse_delay_o = ramp_applied;
   assign window_step_fine_o = st.fine;
   assign dual_edge_sample_o = st.single;
   assign sysref_captured_o = st.capture;
   assign sysref_event_o = st.event_pulse;
endmodule : srw_top
`default_nettype wire

// file: verilog/srw_defs.svh
// Constants for the SYSREF window and delay ramp block
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH
`define SRW_REG_CLK_CTRL 12'h029
`define SRW_REG_POS_LOW 12'h02C
`define SRW_REG_POS_MID 12'h02D
`define SRW_REG_POS_HIGH 12'h02E
`define SRW_REG_POS_VALID 12'h02F
`define SRW_REG_COARSE 12'h038
`define SRW_REG_RAMP_CTRL 12'h039
`define SRW_REG_RAMP_STAT 12'h03A
`define SRW_SEL_LSB 0
`define SRW_SEL_W 4
`define SRW_FINE_BIT 4
`define SRW_SINGLE_BIT 5
`define SRW_RAMP_EN_BIT 0
`define SRW_RAMP_FAST_BIT 1
`define SRW_RAMP_BUSY_BIT 0
`define SRW_VALID_BIT 0
`define SRW_CODE_W 8
`define SRW_TAPS 24
`define SRW_RAMP_PERIOD 384
`define SRW_STEP_SLOW 1
`define SRW_STEP_FAST 4
`define SRW_EDGES_VALID 3
`define SRW_EDGE_UNKNOWN 24'h80_0001
`define SRW_CODE_RESET 8'h00
`endif

// file: verilog/srw_pkg.sv
// Types for the SYSREF window and delay ramp block
`include "srw_defs.svh"
package srw_pkg;
   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } srw_reg_req_t;
   typedef struct packed
   {
      logic [`SRW_CODE_W-1:0] target;
      logic [`SRW_CODE_W-1:0] applied;
      logic [8:0] count;
      logic busy;
   } srw_ramp_state_t;
   typedef struct packed
   {
      logic [`SRW_SEL_W-1:0] sel;
      logic fine;
      logic single;
      logic ramp_en;
      logic ramp_fast;
      logic [`SRW_TAPS-1:0] prev_taps;
      logic [`SRW_TAPS-1:0] flags_prev;
      logic [`SRW_TAPS-1:0] flags;
      logic [1:0] edge_cnt;
      logic capture;
      logic event_pulse;
      logic [7:0] rdata;
   } srw_state_t;
endpackage : srw_pkg

// file: verilog/srw_delay_ramp.sv
// Coarse aperture-delay ramp stepper
`timescale 1ns/1ps
`default_nettype none
`include "srw_defs.svh"
module srw_delay_ramp #(
   parameter int PERIOD = `SRW_RAMP_PERIOD
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic code_wr_i,
   input wire logic [`SRW_CODE_W-1:0] code_i,
   input wire logic ramp_en_i,
   input wire logic ramp_fast_i,
   // State
   output logic [`SRW_CODE_W-1:0] target_o,
   output logic [`SRW_CODE_W-1:0] applied_o,
   output logic busy_o
);
   localparam logic [8:0] LAST = 9'(PERIOD - 1);
   localparam logic [`SRW_CODE_W-1:0] STEP_S = `SRW_CODE_W'(`SRW_STEP_SLOW);
   localparam logic [`SRW_CODE_W-1:0] STEP_F = `SRW_CODE_W'(`SRW_STEP_FAST);
   srw_pkg::srw_ramp_state_t st;
   srw_pkg::srw_ramp_state_t next_st;
   logic [`SRW_CODE_W-1:0] step;
   always_comb
   begin
      next_st = st;
      step = ramp_fast_i ? STEP_F : STEP_S;
      if (code_wr_i)
      begin
         next_st.target = code_i;
         next_st.count = 9'h000;
         if (ramp_en_i)
         begin
            next_st.busy = (code_i != st.applied);
         end
         else
         begin
            next_st.applied = code_i;
            next_st.busy = 1'b0;
         end
      end
      else if (st.busy)
      begin
         if (st.count == LAST)
         begin
            next_st.count = 9'h000;
            // Step toward target without overshoot
            if (st.target > st.applied)
            begin
               if (st.target - st.applied <= step)
                  next_st.applied = st.target;
               else
                  next_st.applied = st.applied + step;
            end
            else
            begin
               if (st.applied - st.target <= step)
                  next_st.applied = st.target;
               else
                  next_st.applied = st.applied - step;
            end
            next_st.busy = (next_st.applied != st.target);
         end
         else
         begin
            next_st.count = st.count + 9'h001;
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '{target: `SRW_CODE_RESET, applied: `SRW_CODE_RESET, count: 9'h000,
                 busy: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end
   assign target_o = st.target;
   assign applied_o = st.applied;
   assign busy_o = st.busy;
endmodule : srw_delay_ramp
`default_nettype wire

// file: sim/srw_monitor.sv
// Checker for the SYSREF window and delay ramp block
`timescale 1ns/1ps
`default_nettype none
module srw_monitor #(
   parameter int RAMP_PERIOD = 384
) (
   // Watched ports of srw_top
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire srw_pkg::srw_reg_req_t reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [23:0] sysref_rise_taps_i,
   input wire logic [23:0] sysref_fall_taps_i,
   input wire logic [7:0] coarse_delay_o,
   input wire logic window_step_fine_o,
   input wire logic dual_edge_sample_o,
   input wire logic sysref_captured_o,
   input wire logic sysref_event_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire w38 = reg_req_i.wr && reg_req_i.addr == 12'h038;
   wire w29 = reg_req_i.wr && reg_req_i.addr == 12'h029;
   wire r29 = reg_req_i.rd && reg_req_i.addr == 12'h029;
   property p_event;
      sysref_event_o == $rose(sysref_captured_o);
   endproperty
   a_event: assert property (p_event) else $error("no event after capture");
   property p_step;
      $changed(coarse_delay_o) && !$past(w38) |-> (coarse_delay_o > $past(coarse_delay_o) ?
         coarse_delay_o - $past(coarse_delay_o) : $past(coarse_delay_o) - coarse_delay_o) <= 8'h04;
   endproperty
   a_step: assert property (p_step) else $error("ramp step too large");
   property p_space;
      $changed(coarse_delay_o) && !$past(w38) |=> (!$changed(coarse_delay_o) || $past(w38))[*7];
   endproperty
   a_space: assert property (p_space) else $error("ramp steps too close");
   property p_low;
      reg_req_i.rd && reg_req_i.addr == 12'h02C |=> reg_rdata_o[0];
   endproperty
   a_low: assert property (p_low) else $error("status bit 0 low");
   property p_high;
      reg_req_i.rd && reg_req_i.addr == 12'h02E |=> reg_rdata_o[7];
   endproperty
   a_high: assert property (p_high) else $error("status bit 23 low");
   property p_ctl_rd;
      r29 |=> reg_rdata_o[5:4] == $past({dual_edge_sample_o, window_step_fine_o});
   endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
   property p_ctl_wr;
      w29 |=> {dual_edge_sample_o, window_step_fine_o} == $past(reg_req_i.wdata[5:4]);
   endproperty
   a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
   property p_coarse_rd;
      reg_req_i.rd && reg_req_i.addr == 12'h038 |=> reg_rdata_o == $past(coarse_delay_o);
   endproperty
   a_coarse_rd: assert property (p_coarse_rd) else $error("coarse readback wrong");
   c_event: cover property (sysref_event_o);
   c_step: cover property ($changed(coarse_delay_o) && !$past(w38));
   c_dual: cover property (dual_edge_sample_o && sysref_captured_o);
endmodule : srw_monitor
bind srw_top srw_monitor #(.RAMP_PERIOD(RAMP_PERIOD)) i_mon (.core_clk_i, .rst_n_i,
   .reg_req_i, .reg_rdata_o, .sysref_rise_taps_i, .sysref_fall_taps_i, .coarse_delay_o,
   .window_step_fine_o, .dual_edge_sample_o, .sysref_captured_o, .sysref_event_o);
`default_nettype wire

// file: sim/srw_clk_src.sv
// Model of the clock source delivering SYSREF to the delayed taps
`timescale 1ns/1ps
`default_nettype none
module srw_clk_src (
   // Clock and control
   input wire logic core_clk_i,
   input wire logic en_i,
   input wire logic [4:0] pos_i,
   // Tap samples
   output logic [23:0] rise_taps_o = 24'h00_0000,
   output logic [23:0] fall_taps_o = 24'h00_0000
);
   logic [3:0] cnt = 4'h0;
   // Periodic SYSREF, same phase in every period
   always @(posedge core_clk_i)
   begin
      cnt <= en_i ? cnt + 4'h1 : 4'h0;
      if (cnt == 4'h1)
      begin
         rise_taps_o <= 24'hFF_FFFF << pos_i;
         fall_taps_o <= 24'hFF_FFFF << (pos_i - 5'h01);
      end
      else if (cnt > 4'h1 && cnt < 4'h5)
      begin
         rise_taps_o <= 24'hFF_FFFF;
         fall_taps_o <= 24'hFF_FFFF;
      end
      else
      begin
         rise_taps_o <= 24'h00_0000;
         fall_taps_o <= 24'h00_0000;
      end
   end
endmodule : srw_clk_src
`default_nettype wire

// file: sim/srw_top_test.sv
// Self-checking testbench for the SYSREF window and delay ramp block
`timescale 1ns/1ps
`default_nettype none
module srw_top_test;
   localparam int P = 8;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   srw_pkg::srw_reg_req_t req = '0;
   logic [7:0] rdata, coarse;
   logic [23:0] rt, ft;
   logic fine, dual, cap, ev;
   logic src_en = 1'b0;
   logic [4:0] pos = 5'h08;
   int errors = 0;
   int comparisons = 0;
   srw_top #(.RAMP_PERIOD(P)) i_dut (.core_clk_i, .rst_n_i, .reg_req_i(req),
      .reg_rdata_o(rdata), .sysref_rise_taps_i(rt), .sysref_fall_taps_i(ft),
      .coarse_delay_o(coarse), .window_step_fine_o(fine), .dual_edge_sample_o(dual),
      .sysref_captured_o(cap), .sysref_event_o(ev));
   srw_clk_src i_src (.core_clk_i, .en_i(src_en), .pos_i(pos), .rise_taps_o(rt),
      .fall_taps_o(ft));
   initial forever #5 core_clk_i = ~core_clk_i;
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(logic [11:0] a, logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      req.wr <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr
   task automatic rd(logic [11:0] a, logic [7:0] exp, string nm);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      req.rd <= 1'b0;
      @(posedge core_clk_i);
      chk(nm, exp, rdata);
   endtask : rd
   task automatic step(logic [7:0] exp, logic gap);
      int n = 0;
      logic [7:0] old;
      old = coarse;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (coarse === old && n < 3 * P);
      chk("coarse", exp, coarse);
      if (gap)
         chk("gap", 8'(P), 8'(n));
   endtask : step
   task automatic wait_ev;
      int n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (ev !== 1'b1 && n < 40);
      chk("event", 8'h01, {7'h00, ev});
   endtask : wait_ev
   task automatic edge_wait;
      int n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (rt !== (24'hFF_FFFF << pos) && n < 40);
      chk("tap_edge", 8'h00, 8'(n >= 40));
      @(posedge core_clk_i);
   endtask : edge_wait
   initial
   begin
      #100000;
      errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd(12'h02C, 8'h01, "pos_low");
      rd(12'h02E, 8'h80, "pos_high");
      rd(12'h02F, 8'h00, "valid");
      rd(12'h029, 8'h00, "clk_ctrl_reset");
      wr(12'h02C, 8'h00);
      rd(12'h02C, 8'h01, "pos_low_ro");
      rd(12'h100, 8'h00, "unmapped");
      $display("test reset done");
      wr(12'h038, 8'h20);
      chk("coarse_direct", 8'h20, coarse);
      wr(12'h039, 8'h01);
      wr(12'h038, 8'h22);
      rd(12'h03A, 8'h01, "busy");
      step(8'h21, 1'b0);
      step(8'h22, 1'b1);
      rd(12'h03A, 8'h00, "idle");
      wr(12'h039, 8'h03);
      wr(12'h038, 8'h2B);
      step(8'h26, 1'b0);
      step(8'h2A, 1'b1);
      step(8'h2B, 1'b1);
      wr(12'h039, 8'h01);
      wr(12'h038, 8'h30);
      step(8'h2C, 1'b0);
      wr(12'h038, 8'h29);
      step(8'h2B, 1'b0);
      step(8'h2A, 1'b1);
      step(8'h29, 1'b1);
      repeat (2 * P) @(posedge core_clk_i);
      chk("held", 8'h29, coarse);
      $display("test ramp done");
      wr(12'h029, 8'h18);
      chk("step_fine", 8'h01, {7'h00, fine});
      rd(12'h029, 8'h18, "clk_ctrl");
      src_en <= 1'b1;
      wait_ev();
      wait_ev();
      rd(12'h02F, 8'h00, "valid_early");
      wait_ev();
      rd(12'h02F, 8'h01, "valid_late");
      rd(12'h02C, 8'h81, "pos_low");
      rd(12'h02D, 8'h01, "pos_mid");
      rd(12'h02E, 8'h80, "pos_high");
      pos <= 5'h0C;
      wait_ev();
      rd(12'h02C, 8'h81, "pos_low_union");
      rd(12'h02D, 8'h19, "pos_mid_union");
      wait_ev();
      rd(12'h02C, 8'h01, "pos_low_new");
      rd(12'h02D, 8'h18, "pos_mid_new");
      $display("test window done");
      for (int s = 0; s < 16; s++)
      begin
         wr(12'h029, 8'h10 | 8'(s));
         edge_wait();
         chk("captured", 8'(s >= 12), {7'h00, cap});
      end
      wr(12'h029, 8'h15);
      edge_wait();
      chk("captured_mid", 8'h00, {7'h00, cap});
      wr(12'h029, 8'h3B);
      edge_wait();
      chk("captured_dual", 8'h01, {7'h00, cap});
      chk("dual_edge", 8'h01, {7'h00, dual});
      $display("test capture done");
      tally_and_finish();
   end
endmodule : srw_top_test
`default_nettype wire
